// >>> hdl/usb_rs_map.svh
`ifndef USB_RS_MAP_SVH
`define USB_RS_MAP_SVH

// Clock and link rates
`define REF_CLK_KHZ 25000
`define USB_BIT_RATE_KHZ 12000

// Frame period
`define FRAME_TIME_US 1000
`define FRAME_CYCLES ((`FRAME_TIME_US * `REF_CLK_KHZ) / 1000)
`define FRAME_CNT_W 15

// Connect detect delay after soft reset, least time rounded up
`define DETECT_BIT_TIMES 64
`define DETECT_CYCLES \
  ((`DETECT_BIT_TIMES * `REF_CLK_KHZ + `USB_BIT_RATE_KHZ - 1) / `USB_BIT_RATE_KHZ)
`define DETECT_CNT_W 8

// Length of the internal soft reset process
`define SOFT_RESET_CYCLES 4
`define SOFT_CNT_W 3

// Port status field positions
`define PSC_CONNECT 0
`define PSC_CONNECT_CHG 1
`define PSC_ENABLE 2
`define PSC_ENABLE_CHG 3
`define PSC_LOW_SPEED 8
`define PSC_W 9

// Frame index width and root hub port count
`define FRAME_INDEX_W 11
`define NUM_PORTS 2

`endif

// >>> hdl/usb_rs_pkg.sv
`default_nettype none
package usb_rs_pkg;
  // Schedule run control states
  typedef enum logic [1:0] {RUN_HALTED, RUN_ACTIVE, RUN_DRAIN} run_state_t;
  // Per port connect/disconnect states
  typedef enum logic [1:0] {PORT_DISCONN, PORT_DETECT, PORT_CONN} port_state_t;
endpackage
`default_nettype wire

// >>> hdl/port_link_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "usb_rs_map.svh"
// Signals between the run controller and one port state machine
interface port_link_if;
  logic soft_reset; // Controller soft reset in progress
  logic attach; // Device presence sensed on the port
  logic low_speed_in; // Low speed sensed on the port
  logic enable_set; // Software enables the port
  logic clr_connect_chg; // Software clears connect change
  logic clr_enable_chg; // Software clears enable change
  logic [`PSC_W-1:0] status; // Port status bits
  modport ctl (output soft_reset, attach, low_speed_in, enable_set, clr_connect_chg,
    clr_enable_chg, input status);
  modport port (input soft_reset, attach, low_speed_in, enable_set, clr_connect_chg,
    clr_enable_chg, output status);
endinterface
`default_nettype wire

// >>> hdl/port_connect_fsm.sv
`timescale 1ns/100ps
`default_nettype none
`include "usb_rs_map.svh"
module port_connect_fsm
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link to controller
  port_link_if.port link
);
  usb_rs_pkg::port_state_t state; // Connect/disconnect state
  logic [`DETECT_CNT_W-1:0] detect_cnt; // Bit time delay counter
  logic connect; // Port bit 0
  logic connect_chg; // Port bit 1
  logic enable; // Port bit 2
  logic enable_chg; // Port bit 3
  logic low_speed; // Port bit 8
  logic detect_done; // Delay after soft reset has run out
  logic lost; // Connected device went away

  assign detect_done = detect_cnt == `DETECT_CNT_W'(`DETECT_CYCLES - 1);
  assign lost = state == usb_rs_pkg::PORT_CONN && !link.attach;

  // Connect state machine, forced back by soft reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state <= usb_rs_pkg::PORT_DISCONN;
    else if (link.soft_reset)
      state <= usb_rs_pkg::PORT_DETECT;
    else
    begin
      case (state)
        usb_rs_pkg::PORT_DETECT:
          // Redetect once the delay has elapsed
          if (detect_done)
            state <= link.attach ? usb_rs_pkg::PORT_CONN : usb_rs_pkg::PORT_DISCONN;
        usb_rs_pkg::PORT_DISCONN:
          if (link.attach)
            state <= usb_rs_pkg::PORT_CONN;
        usb_rs_pkg::PORT_CONN:
          if (!link.attach)
            state <= usb_rs_pkg::PORT_DISCONN;
        default:
          state <= usb_rs_pkg::PORT_DISCONN;
      endcase
    end
  end

  // Delay counter, restarts during soft reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      detect_cnt <= '0;
    else if (link.soft_reset || state != usb_rs_pkg::PORT_DETECT)
      detect_cnt <= '0;
    else if (!detect_done)
      detect_cnt <= detect_cnt + `DETECT_CNT_W'(1);
  end

  // Connect and low speed bits
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      connect <= 1'b0;
      low_speed <= 1'b0;
    end
    else if (link.soft_reset)
    begin
      connect <= 1'b0;
      low_speed <= 1'b0;
    end
    else if ((state == usb_rs_pkg::PORT_DETECT && detect_done) ||
      (state == usb_rs_pkg::PORT_DISCONN && link.attach))
    begin
      connect <= link.attach;
      low_speed <= link.attach && link.low_speed_in;
    end
    else if (lost)
    begin
      connect <= 1'b0;
      low_speed <= 1'b0;
    end
  end

  // Port enable, dropped by any disconnect
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      enable <= 1'b0;
    else if (link.soft_reset || lost)
      enable <= 1'b0;
    else if (link.enable_set && connect)
      enable <= 1'b1;
  end

  // Connect change, set wins over software clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      connect_chg <= 1'b0;
    else if (link.soft_reset || lost || (state == usb_rs_pkg::PORT_DISCONN && link.attach) ||
      (state == usb_rs_pkg::PORT_DETECT && detect_done && link.attach))
      connect_chg <= 1'b1;
    else if (link.clr_connect_chg)
      connect_chg <= 1'b0;
  end

  // Enable change, set wins over software clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      enable_chg <= 1'b0;
    else if (link.soft_reset || (lost && enable))
      enable_chg <= 1'b1;
    else if (link.clr_enable_chg)
      enable_chg <= 1'b0;
  end

  // Only bits 8 and 3:0 live here; 7:4 are tied to zero
  assign link.status = {low_speed, 4'h0, enable_chg, enable, connect_chg, connect};
endmodule
`default_nettype wire

// >>> hdl/usb_run_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "usb_rs_map.svh"
module usb_run_control
#(
  parameter logic [`FRAME_CNT_W-1:0] FRAME_CYCLES = `FRAME_CNT_W'(`FRAME_CYCLES)
)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Command register write
  input wire logic CMD_WR,
  input wire logic CMD_RUN_STOP,
  input wire logic CMD_SOFT_RESET,
  input wire logic CMD_SINGLE_STEP,
  // Frame index write
  input wire logic FRAME_INDEX_WR,
  input wire logic [`FRAME_INDEX_W-1:0] FRAME_INDEX_WDATA,
  // Schedule engine
  input wire logic TXN_ACTIVE,
  input wire logic TXN_DONE,
  input wire logic TD_FETCH,
  input wire logic CONSIST_ERR,
  input wire logic PCI_ERR,
  // Root hub ports
  input wire logic [`NUM_PORTS-1:0] PORT_ATTACH,
  input wire logic [`NUM_PORTS-1:0] PORT_LOW_SPEED_IN,
  input wire logic [`NUM_PORTS-1:0] PORT_ENABLE_SET,
  input wire logic [`NUM_PORTS-1:0] PORT_CLR_CONNECT_CHG,
  input wire logic [`NUM_PORTS-1:0] PORT_CLR_ENABLE_CHG,
  // Command and status bits
  output logic RUN_STOP,
  output logic SOFT_RESET,
  output logic SINGLE_STEP,
  output logic HALTED,
  // Schedule control
  output logic SCHED_GO,
  output logic TXN_ABORT,
  output logic SOF_PULSE,
  output logic [`FRAME_INDEX_W-1:0] FRAME_INDEX,
  // Port status
  output logic [`NUM_PORTS-1:0][`PSC_W-1:0] PORT_STATUS
);
  usb_rs_pkg::run_state_t run_state; // Schedule run state
  usb_rs_pkg::run_state_t next_run_state; // Next run state
  logic [`SOFT_CNT_W-1:0] soft_cnt; // Soft reset duration counter
  logic [`FRAME_CNT_W-1:0] frame_cnt; // Position within the frame
  logic frame_end; // Last cycle of a frame
  logic fatal; // Any fatal error
  logic soft_last; // Final cycle of the soft reset process

  assign fatal = CONSIST_ERR || PCI_ERR;
  assign soft_last = SOFT_RESET && soft_cnt == `SOFT_CNT_W'(`SOFT_RESET_CYCLES - 1);
  assign frame_end = frame_cnt == FRAME_CYCLES - `FRAME_CNT_W'(1);

  // Soft reset bit, cleared by hardware when done
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      SOFT_RESET <= 1'b0;
    else if (soft_last)
      SOFT_RESET <= 1'b0;
    else if (CMD_WR && CMD_SOFT_RESET)
      SOFT_RESET <= 1'b1;
  end

  // Soft reset duration
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      soft_cnt <= '0;
    else if (!SOFT_RESET)
      soft_cnt <= '0;
    else
      soft_cnt <= soft_cnt + `SOFT_CNT_W'(1);
  end

  // Abort the bus transaction for one cycle when soft reset is written
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      TXN_ABORT <= 1'b0;
    else
      TXN_ABORT <= CMD_WR && CMD_SOFT_RESET && !soft_last;
  end

  // Run/stop bit; hardware clears win over software writes
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      RUN_STOP <= 1'b0;
    else if (SOFT_RESET)
      RUN_STOP <= 1'b0;
    else if (fatal)
      RUN_STOP <= 1'b0;
    else if (SINGLE_STEP && RUN_STOP && TD_FETCH)
      RUN_STOP <= 1'b0;
    else if (CMD_WR)
      RUN_STOP <= CMD_RUN_STOP;
  end

  // Single step debug bit, software can change it at any time except during soft reset
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      SINGLE_STEP <= 1'b0;
    else if (SOFT_RESET)
      SINGLE_STEP <= 1'b0;
    else if (CMD_WR)
      SINGLE_STEP <= CMD_SINGLE_STEP;
  end

  // Next run state
  always_comb
  begin
    next_run_state = run_state;
    case (run_state)
      usb_rs_pkg::RUN_HALTED:
        if (RUN_STOP)
          next_run_state = usb_rs_pkg::RUN_ACTIVE;
      usb_rs_pkg::RUN_ACTIVE:
        // Stop at once when idle, otherwise finish the transaction
        if (!RUN_STOP)
          next_run_state = TXN_ACTIVE && !TXN_DONE ? usb_rs_pkg::RUN_DRAIN
            : usb_rs_pkg::RUN_HALTED;
      usb_rs_pkg::RUN_DRAIN:
        if (TXN_DONE || !TXN_ACTIVE)
          next_run_state = usb_rs_pkg::RUN_HALTED;
      default:
        next_run_state = usb_rs_pkg::RUN_HALTED;
    endcase
  end

  // Run state register; soft reset returns to halted
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      run_state <= usb_rs_pkg::RUN_HALTED;
    else if (SOFT_RESET)
      run_state <= usb_rs_pkg::RUN_HALTED;
    else
      run_state <= next_run_state;
  end

  // Halted flag follows the run state
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      HALTED <= 1'b1;
    else if (SOFT_RESET)
      HALTED <= 1'b1;
    else if (next_run_state == usb_rs_pkg::RUN_HALTED)
      HALTED <= 1'b1;
    else
      HALTED <= 1'b0;
  end

  // New transactions only while running and run/stop holds
  assign SCHED_GO = run_state == usb_rs_pkg::RUN_ACTIVE && RUN_STOP;

  // Frame counter: cleared or frozen while stopped, by debug mode
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      frame_cnt <= '0;
    else if (SOFT_RESET)
      frame_cnt <= '0;
    else if (run_state == usb_rs_pkg::RUN_HALTED)
    begin
      if (!SINGLE_STEP)
        frame_cnt <= '0;
    end
    else if (frame_end)
      frame_cnt <= '0;
    else
      frame_cnt <= frame_cnt + `FRAME_CNT_W'(1);
  end

  // Start of frame marker; debug-off resume starts here
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      SOF_PULSE <= 1'b0;
    else
      SOF_PULSE <= !SOFT_RESET && run_state == usb_rs_pkg::RUN_ACTIVE &&
        frame_cnt == '0;
  end

  // Frame index: rewritable while halted, advances each frame
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      FRAME_INDEX <= '0;
    else if (SOFT_RESET)
      FRAME_INDEX <= '0;
    else if (run_state == usb_rs_pkg::RUN_HALTED && FRAME_INDEX_WR)
      FRAME_INDEX <= FRAME_INDEX_WDATA;
    else if (run_state != usb_rs_pkg::RUN_HALTED && frame_end)
      FRAME_INDEX <= FRAME_INDEX + `FRAME_INDEX_W'(1);
  end

  // One connect state machine per root hub port
  generate
    for (genvar p = 0; p < `NUM_PORTS; p++)
    begin : g_port
      port_link_if link ();
      assign link.soft_reset = SOFT_RESET;
      assign link.attach = PORT_ATTACH[p];
      assign link.low_speed_in = PORT_LOW_SPEED_IN[p];
      assign link.enable_set = PORT_ENABLE_SET[p];
      assign link.clr_connect_chg = PORT_CLR_CONNECT_CHG[p];
      assign link.clr_enable_chg = PORT_CLR_ENABLE_CHG[p];
      assign PORT_STATUS[p] = link.status;
      port_connect_fsm u_port (
        .clk(REF_CLK),
        .rst(RST),
        .link(link.port)
      );
    end
  endgenerate
endmodule
`default_nettype wire

// >>> sim/usb_run_control_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "usb_rs_map.svh"
module usb_run_control_properties
#(
  parameter logic [`FRAME_CNT_W-1:0] FRAME_CYCLES = `FRAME_CNT_W'(`FRAME_CYCLES)
)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Frame index write and engine inputs
  input wire logic FRAME_INDEX_WR,
  input wire logic TXN_ACTIVE,
  input wire logic TD_FETCH,
  input wire logic CONSIST_ERR,
  input wire logic PCI_ERR,
  // Outputs watched
  input wire logic RUN_STOP,
  input wire logic SOFT_RESET,
  input wire logic SINGLE_STEP,
  input wire logic HALTED,
  input wire logic SCHED_GO,
  input wire logic TXN_ABORT,
  input wire logic SOF_PULSE,
  input wire logic [`FRAME_INDEX_W-1:0] FRAME_INDEX,
  input wire logic [`NUM_PORTS-1:0][`PSC_W-1:0] PORT_STATUS
);
  // One clock domain
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  // Soft reset runs four cycles, then clears itself
  chk_soft_self_clear: assert property ($rose(SOFT_RESET) |->
    SOFT_RESET[*4] ##1 !SOFT_RESET)
    else $error("soft reset length wrong");
  chk_abort_on_reset: assert property ($rose(SOFT_RESET) |-> TXN_ABORT)
    else $error("no abort at soft reset");
  chk_reset_halts: assert property (SOFT_RESET |=> !RUN_STOP && HALTED)
    else $error("soft reset left controller running");
  chk_port_vdisc: assert property (SOFT_RESET && $past(SOFT_RESET) |->
    ((PORT_STATUS[0] & 9'h10F) == 9'h00A) && ((PORT_STATUS[1] & 9'h10F) == 9'h00A))
    else $error("port not disconnected in soft reset");
  chk_port_spare: assert property ((PORT_STATUS[0][7:4] == 4'h0) &&
    (PORT_STATUS[1][7:4] == 4'h0))
    else $error("spare port bits moved");
  chk_fatal_clear: assert property (CONSIST_ERR || PCI_ERR |=> !RUN_STOP)
    else $error("fatal error left run set");
  chk_step_fetch: assert property (SINGLE_STEP && RUN_STOP && TD_FETCH |=> !RUN_STOP)
    else $error("single step fetch left run set");
  chk_idle_halt: assert property ($fell(RUN_STOP) && !TXN_ACTIVE |-> ##[0:1] HALTED)
    else $error("idle stop did not halt");
  chk_go_running: assert property (SCHED_GO |-> RUN_STOP && !HALTED)
    else $error("schedule go while stopped");
  chk_run_unhalt: assert property ($rose(RUN_STOP) |=> !HALTED)
    else $error("halted stayed after run");
  chk_halt_frame: assert property (HALTED && $past(HALTED) &&
    !$past(FRAME_INDEX_WR) && !SOFT_RESET |-> $stable(FRAME_INDEX))
    else $error("frame index moved while halted");
  // Main scenarios
  cov_sof_run: cover property (SOF_PULSE && !HALTED);
  cov_soft: cover property ($rose(SOFT_RESET));
  cov_step: cover property (SINGLE_STEP && RUN_STOP && TD_FETCH);
endmodule
bind usb_run_control usb_run_control_properties #(.FRAME_CYCLES(FRAME_CYCLES)) u_props (
  .REF_CLK(REF_CLK), .RST(RST), .FRAME_INDEX_WR(FRAME_INDEX_WR), .TXN_ACTIVE(TXN_ACTIVE),
  .TD_FETCH(TD_FETCH), .CONSIST_ERR(CONSIST_ERR), .PCI_ERR(PCI_ERR), .RUN_STOP(RUN_STOP),
  .SOFT_RESET(SOFT_RESET), .SINGLE_STEP(SINGLE_STEP), .HALTED(HALTED), .SCHED_GO(SCHED_GO),
  .TXN_ABORT(TXN_ABORT), .SOF_PULSE(SOF_PULSE), .FRAME_INDEX(FRAME_INDEX),
  .PORT_STATUS(PORT_STATUS));
`default_nettype wire

// >>> sim/usb_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "usb_rs_map.svh"
module usb_dev_model
(
  // Clock
  input wire logic clk,
  // Plug controls from the bench
  input wire logic [`NUM_PORTS-1:0] plug,
  input wire logic [`NUM_PORTS-1:0] low,
  // Lines sensed by the root hub
  output logic [`NUM_PORTS-1:0] attach,
  output logic [`NUM_PORTS-1:0] low_speed
);
  // Floating speed line on an empty port changes every cycle
  logic [`NUM_PORTS-1:0] noise = '0;
  always @(posedge clk) noise <= ~noise;
  // Presence and speed follow the plugged device
  assign attach = plug;
  assign low_speed = (plug & low) | (~plug & noise);
endmodule
`default_nettype wire

// >>> sim/tb_usb_run_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "usb_rs_map.svh"
module tb_usb_run_control;
  localparam int FRAMES = 20; // Short frame for the run
  logic clk, rst, wr, rs, sr, ss, txn_act, run_stop, soft_reset, single_step, halted;
  logic sched_go, txn_abort, sof;
  logic [4:0] pv; // Pulses: done, fetch, consist, pci, index write
  logic [`FRAME_INDEX_W-1:0] fi_wdata, frame_index, f0;
  logic [`NUM_PORTS-1:0] plug, low, attach, ls_in, en_set, clr_cc, clr_ec;
  logic [`NUM_PORTS-1:0][`PSC_W-1:0] port_status;
  int err_count, checks_done, n;
  // Device under test
  usb_run_control #(.FRAME_CYCLES(`FRAME_CNT_W'(FRAMES))) u_dut (.REF_CLK(clk), .RST(rst),
    .CMD_WR(wr), .CMD_RUN_STOP(rs), .CMD_SOFT_RESET(sr), .CMD_SINGLE_STEP(ss),
    .FRAME_INDEX_WR(pv[4]), .FRAME_INDEX_WDATA(fi_wdata), .TXN_ACTIVE(txn_act),
    .TXN_DONE(pv[0]), .TD_FETCH(pv[1]), .CONSIST_ERR(pv[2]), .PCI_ERR(pv[3]),
    .PORT_ATTACH(attach), .PORT_LOW_SPEED_IN(ls_in), .PORT_ENABLE_SET(en_set),
    .PORT_CLR_CONNECT_CHG(clr_cc), .PORT_CLR_ENABLE_CHG(clr_ec), .RUN_STOP(run_stop),
    .SOFT_RESET(soft_reset), .SINGLE_STEP(single_step), .HALTED(halted), .SCHED_GO(sched_go),
    .TXN_ABORT(txn_abort), .SOF_PULSE(sof), .FRAME_INDEX(frame_index), .PORT_STATUS(port_status));
  // Devices on the root hub ports
  usb_dev_model u_dev (.clk(clk), .plug(plug), .low(low), .attach(attach), .low_speed(ls_in));
  // Wait edges, then let updates settle
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Command register write
  task automatic cmd(input logic r, input logic s, input logic d);
    @(posedge clk);
    wr <= 1'b1;
    rs <= r;
    sr <= s;
    ss <= d;
    @(posedge clk);
    wr <= 1'b0;
    sr <= 1'b0;
  endtask
  // One-cycle engine pulse
  task automatic pulse(input int i);
    @(posedge clk);
    pv[i] <= 1'b1;
    @(posedge clk);
    pv[i] <= 1'b0;
  endtask
  // Bounded wait for a level
  task automatic wait_val(input string what, ref logic s, input logic v, input int lim);
    #1;
    n = 0;
    while (s !== v && n < lim)
    begin
      step(1);
      n++;
    end
    chk(what, v, s);
  endtask
  // Verdict
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Watchdog
  initial
  begin
    #200000;
    err_count++;
    summarize();
  end
  // Test sequence
  initial
  begin
    {rst, wr, rs, sr, ss, txn_act, pv, fi_wdata} = {6'h20, 5'h0, 11'h0};
    {plug, low, en_set, clr_cc, clr_ec} = {2'b11, 2'b10, 6'h0};
    err_count = 0;
    checks_done = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    step(1);
    chk("halted", 1, halted);
    chk("frame_index", 0, frame_index);
    cmd(1, 0, 0);
    step(2);
    chk("halted", 0, halted);
    chk("sched_go", 1, sched_go);
    wait_val("sof", sof, 1'b1, 30);
    f0 = frame_index;
    step(FRAMES);
    chk("frame_index", f0 + 11'h1, frame_index);
    @(posedge clk) txn_act <= 1'b1;
    cmd(0, 0, 0);
    step(4);
    chk("drain halted", 0, halted);
    pulse(0);
    @(posedge clk) txn_act <= 1'b0;
    step(1);
    chk("halted", 1, halted);
    @(posedge clk) fi_wdata <= 11'h123;
    pulse(4);
    step(1);
    chk("frame_index", 11'h123, frame_index);
    cmd(1, 0, 0);
    wait_val("sof", sof, 1'b1, 4);
    for (int e = 2; e < 4; e++)
    begin
      pulse(e);
      step(0);
      chk("run_stop", 0, run_stop);
      step(1);
      chk("halted", 1, halted);
      cmd(1, 0, 0);
      step(2);
    end
    cmd(0, 0, 0);
    step(2);
    cmd(0, 0, 1);
    step(0);
    chk("single_step", 1, single_step);
    cmd(1, 0, 1);
    step(2);
    @(posedge clk) txn_act <= 1'b1;
    pulse(1);
    step(0);
    chk("step run_stop", 0, run_stop);
    pulse(0);
    @(posedge clk) txn_act <= 1'b0;
    step(1);
    chk("step halted", 1, halted);
    f0 = frame_index;
    step(FRAMES * 2);
    chk("frozen index", f0, frame_index);
    cmd(0, 0, 0);
    for (int k = 0; k < 2; k++)
    begin
      cmd(1, 0, 0);
      @(posedge clk) txn_act <= 1'b1;
      cmd(1, 1, 0);
      step(0);
      chk("txn_abort", 1, txn_abort);
      chk("soft_reset", 1, soft_reset);
      @(posedge clk) txn_act <= 1'b0;
      wait_val("soft_reset", soft_reset, 1'b0, 8);
      chk("run_stop", 0, run_stop);
      chk("halted", 1, halted);
      chk("frame_index", 0, frame_index);
      chk("port0", 9'h00A, port_status[0]);
      chk("port1", 9'h00A, port_status[1]);
      step(140);
      chk("port0", 9'h00B, port_status[0]);
      chk("port1", 9'h10B, port_status[1]);
      @(posedge clk) en_set <= 2'b11;
      @(posedge clk) en_set <= 2'b00;
      {clr_cc, clr_ec} <= 4'hF;
      @(posedge clk) {clr_cc, clr_ec} <= 4'h0;
      step(2);
      chk("port0", 9'h005, port_status[0]);
      chk("port1", 9'h105, port_status[1]);
    end
    // Unplug and replug the low speed device on port 1
    @(posedge clk) plug <= 2'b01;
    step(2);
    chk("unplug port1", 9'h00A, port_status[1]);
    chk("unplug port0", 9'h005, port_status[0]);
    @(posedge clk) plug <= 2'b11;
    step(2);
    chk("replug port1", 9'h10B, port_status[1]);
    // Chip reset in mid-run
    cmd(1, 0, 0);
    step(2);
    @(posedge clk) rst <= 1'b1;
    step(1);
    chk("reset halted", 1, halted);
    chk("reset run_stop", 0, run_stop);
    @(posedge clk) rst <= 1'b0;
    step(1);
    chk("reset port0", 9'h003, port_status[0]);
    chk("reset port1", 9'h103, port_status[1]);
    summarize();
  end
endmodule
`default_nettype wire
